// ---- verilog/dsor_pkg.sv ----
// Constants for the frequency step unit and the output clock routing.
// Assumes a 7-bit register index and 16-bit register data.
package dsor_pkg;

	// Register indices
	localparam logic [6:0]  OFS_FINE_TUNE  = 7'h03;
	localparam logic [6:0]  OFS_BYPASS     = 7'h19;
	localparam logic [6:0]  OFS_STEP_SIZE  = 7'h2b;
	localparam logic [6:0]  OFS_PRESCALE   = 7'h2f;
	localparam logic [6:0]  OFS_CH_ONE     = 7'h38;
	localparam logic [6:0]  OFS_CMOS_ONE   = 7'h3b;
	localparam logic [6:0]  OFS_CH_TWO     = 7'h3e;
	localparam logic [6:0]  OFS_CH_THREE   = 7'h43;
	localparam logic [6:0]  OFS_CH_FOUR    = 7'h48;
	localparam logic [6:0]  OFS_CMOS_FOUR  = 7'h4b;

	// Reset value of every register
	localparam logic [15:0] REG_RESET      = 16'h0000;

	// Fine-tune control fields
	localparam int          FT_ENABLE_BIT  = 3;
	localparam int          FT_SERIAL_BIT  = 4;
	localparam int          FT_UP_BIT      = 5;
	localparam int          FT_DOWN_BIT    = 6;

	// Bypass routing fields
	localparam int          BYP_SRC_BIT    = 9;
	localparam int          BYP_ZERO_BIT   = 10;
	localparam int          BYP_ROUTE_LSB  = 11;

	// Prescaler fields and codes
	localparam int          PS_A_LSB       = 3;
	localparam int          PS_B_LSB       = 5;
	localparam logic [1:0]  PS_CODE_DIV5   = 2'h1;
	localparam logic [1:0]  PS_CODE_DIV6   = 2'h2;
	localparam logic [2:0]  PS_DIV4        = 3'h4;
	localparam logic [2:0]  PS_DIV5        = 3'h5;
	localparam logic [2:0]  PS_DIV6        = 3'h6;

	// Channel register fields and source codes
	localparam int          CH_SRC_LSB     = 14;
	localparam int          CH_DIV_W       = 14;
	localparam logic [1:0]  SRC_PSA        = 2'h0;
	localparam logic [1:0]  SRC_PSB        = 2'h1;

	// Output polarity fields: bit for positive pin, bit for negative pin
	localparam int          POL1_P_BIT     = 11;
	localparam int          POL1_N_BIT     = 12;
	localparam int          POL4_P_BIT     = 12;
	localparam int          POL4_N_BIT     = 11;

	// Numerator width of the sigma-delta modulator
	localparam int          NUM_W          = 24;

endpackage : dsor_pkg

// ---- verilog/dsor_int_divider.sv ----
// Integer clock divider driven by sampled edges of a source level.
// Assumes src_rise is a one-cycle pulse on each rising edge of src_level.
`timescale 1ns/100ps
module dsor_int_divider #(
	parameter int W = 14
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// Source
	input  wire logic         src_level,
	input  wire logic         src_rise,
	// Divide value, below two passes the source through
	input  wire logic [W-1:0] div_value,
	// Divided clock
	output logic              div_out
);

	logic [W-1:0] cnt;
	logic [W-1:0] cur_div;
	logic [W-1:0] next_cnt;
	logic [W-1:0] next_div;
	logic         next_out;

	// New value taken at the period boundary, or at once while passing through, so no divided pulse is cut short
	always_comb
	begin
		next_cnt = cnt;
		next_div = cur_div;
		if (cur_div < W'(2))
		begin
			next_div = div_value;
			next_cnt = '0;
		end
		else if (src_rise)
		begin
			if (cnt == cur_div - W'(1))
			begin
				next_cnt = '0;
				next_div = div_value;
			end
			else
			begin
				next_cnt = cnt + W'(1);
			end
		end
		if (next_div < W'(2))
			next_out = src_level;
		else
			next_out = (next_cnt < (next_div >> 1));
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cnt     <= '0;
			cur_div <= '0;
			div_out <= 1'b0;
		end
		else
		begin
			cnt     <= next_cnt;
			cur_div <= next_div;
			div_out <= next_out;
		end
	end

endmodule : dsor_int_divider

// ---- verilog/dsor_top.sv ----
// Frequency step unit for the modulator numerator and output clock routing.
// Assumes register writes arrive already decoded from the serial interface
// on mclk; step pins and clock sources are asynchronous and sampled here.
//
// Contract
// [RQ1] Step amount comes from the 16-bit step size register.
// [RQ2] Each step adds or subtracts the step size on the numerator.
// [RQ3] Each rising edge of the up request raises frequency one step.
// [RQ4] Each rising edge of the down request lowers frequency one step.
// [RQ5] Control bit 3 enables fine tune; bit 4 picks pins or serial.
// [RQ6] In serial mode, writing request bits produces the step triggers.
// [RQ7] In pin mode, the controller drives one rising edge per step.
// [RQ8] With fine tune disabled, requests are ignored, numerator unchanged.
// [RQ9] Two prescalers divide the oscillator by four, five or six.
// [RQ10] Each of four channels has its own glitchless integer divider.
// [RQ11] Each channel divider takes prescaler a, b or the reference.
// [RQ12] Bits 15:14 of each channel register select its source.
// [RQ13] A channel divider can be bypassed to pass the reference.
// [RQ14] Four bypass register bits route the reference to outputs one-four.
// [RQ15] One bypass bit enables output zero, carrying reference or detector.
// [RQ16] One bypass bit picks detector clock or reference for output zero.
// [RQ17] CMOS positive and negative pin polarities are set independently.
`timescale 1ns/100ps
module dsor_top (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Register port
	input  wire logic [6:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	output logic      [15:0] reg_rdata,
	// Step request pins
	input  wire logic        freq_up_pulse,
	input  wire logic        freq_down_pulse,
	// Modulator numerator
	input  wire logic [23:0] numerator_base,
	output logic      [23:0] sdm_numerator,
	// Clock sources
	input  wire logic        vco_clk,
	input  wire logic        ref_clk,
	input  wire logic        pfd_clk,
	// Clock outputs
	output logic             clock_output_zero,
	output logic      [3:0]  out_p,
	output logic      [3:0]  out_n
);

	localparam int NS = 5;
	localparam int IU = 0;
	localparam int ID = 1;
	localparam int IV = 2;
	localparam int IR = 3;
	localparam int IP = 4;
	localparam int NUM_W = dsor_pkg::NUM_W;

	// Register storage
	logic [15:0] fine_tune_control;
	logic [15:0] bypass_routing_control;
	logic [15:0] frequency_step_size;
	logic [15:0] prescale_control;
	logic [15:0] channel_source [4];
	logic [15:0] cmos_pol_one;
	logic [15:0] cmos_pol_four;
	logic [15:0] next_ft;
	logic [15:0] next_byp;
	logic [15:0] next_step;
	logic [15:0] next_ps;
	logic [15:0] next_ch [4];
	logic [15:0] next_cm1;
	logic [15:0] next_cm4;
	logic [15:0] next_rdata;

	// Synchronisers and edge history
	logic [NS-1:0] sync_a;
	logic [NS-1:0] sync_b;
	logic [NS-1:0] sync_prev;
	logic [NS-1:0] rise;

	// Step datapath
	logic              fine_tune_enable;
	logic              step_trigger_source_select;
	logic              sw_up_event;
	logic              sw_down_event;
	logic              up_req;
	logic              down_req;
	logic [NUM_W-1:0]  step_ext;
	logic [NUM_W-1:0]  num_ofs;
	logic [NUM_W-1:0]  next_ofs;
	logic [NUM_W-1:0]  next_num;

	// Clock routing
	logic       prescaler_a;
	logic       prescaler_b;
	logic [3:0] sel_level;
	logic [3:0] sel_prev;
	logic [3:0] div_out;
	logic [3:0] pol_p;
	logic [3:0] pol_n;
	logic [3:0] next_p;
	logic [3:0] next_n;
	logic       next_zero;

	function automatic logic [2:0] ps_divisor(input logic [1:0] code);
		unique case (code)
			dsor_pkg::PS_CODE_DIV5: ps_divisor = dsor_pkg::PS_DIV5;
			dsor_pkg::PS_CODE_DIV6: ps_divisor = dsor_pkg::PS_DIV6;
			default:                ps_divisor = dsor_pkg::PS_DIV4;
		endcase
	endfunction : ps_divisor

	function automatic logic src_pick(input logic [1:0] sel,
		input logic a, input logic b, input logic r);
		unique case (sel)
			dsor_pkg::SRC_PSA: src_pick = a;
			dsor_pkg::SRC_PSB: src_pick = b;
			default:           src_pick = r;
		endcase
	endfunction : src_pick

	// Register writes and read data
	always_comb
	begin
		next_ft   = fine_tune_control;
		next_byp  = bypass_routing_control;
		next_step = frequency_step_size;
		next_ps   = prescale_control;
		next_cm1  = cmos_pol_one;
		next_cm4  = cmos_pol_four;
		for (int i = 0; i < 4; i++)
			next_ch[i] = channel_source[i];
		if (reg_wr)
		begin
			unique case (reg_addr)
				dsor_pkg::OFS_FINE_TUNE: next_ft   = reg_wdata;
				dsor_pkg::OFS_BYPASS:    next_byp  = reg_wdata;
				dsor_pkg::OFS_STEP_SIZE: next_step = reg_wdata;
				dsor_pkg::OFS_PRESCALE:  next_ps   = reg_wdata;
				dsor_pkg::OFS_CH_ONE:    next_ch[0] = reg_wdata;
				dsor_pkg::OFS_CH_TWO:    next_ch[1] = reg_wdata;
				dsor_pkg::OFS_CH_THREE:  next_ch[2] = reg_wdata;
				dsor_pkg::OFS_CH_FOUR:   next_ch[3] = reg_wdata;
				dsor_pkg::OFS_CMOS_ONE:  next_cm1  = reg_wdata;
				dsor_pkg::OFS_CMOS_FOUR: next_cm4  = reg_wdata;
				default:                 next_ft   = fine_tune_control;
			endcase
		end
		unique case (reg_addr)
			dsor_pkg::OFS_FINE_TUNE: next_rdata = fine_tune_control;
			dsor_pkg::OFS_BYPASS:    next_rdata = bypass_routing_control;
			dsor_pkg::OFS_STEP_SIZE: next_rdata = frequency_step_size;
			dsor_pkg::OFS_PRESCALE:  next_rdata = prescale_control;
			dsor_pkg::OFS_CH_ONE:    next_rdata = channel_source[0];
			dsor_pkg::OFS_CH_TWO:    next_rdata = channel_source[1];
			dsor_pkg::OFS_CH_THREE:  next_rdata = channel_source[2];
			dsor_pkg::OFS_CH_FOUR:   next_rdata = channel_source[3];
			dsor_pkg::OFS_CMOS_ONE:  next_rdata = cmos_pol_one;
			dsor_pkg::OFS_CMOS_FOUR: next_rdata = cmos_pol_four;
			default:                 next_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			fine_tune_control      <= dsor_pkg::REG_RESET;
			bypass_routing_control <= dsor_pkg::REG_RESET;
			frequency_step_size    <= dsor_pkg::REG_RESET;
			prescale_control       <= dsor_pkg::REG_RESET;
			cmos_pol_one           <= dsor_pkg::REG_RESET;
			cmos_pol_four          <= dsor_pkg::REG_RESET;
			reg_rdata              <= 16'h0000;
			for (int i = 0; i < 4; i++)
				channel_source[i] <= dsor_pkg::REG_RESET;
		end
		else
		begin
			fine_tune_control      <= next_ft;
			bypass_routing_control <= next_byp;
			frequency_step_size    <= next_step;
			prescale_control       <= next_ps;
			cmos_pol_one           <= next_cm1;
			cmos_pol_four          <= next_cm4;
			reg_rdata              <= next_rdata;
			for (int i = 0; i < 4; i++)
				channel_source[i] <= next_ch[i];
		end
	end

	// Pins and source clocks: two stages, then edge history on stage two
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			sync_a    <= '0;
			sync_b    <= '0;
			sync_prev <= '0;
		end
		else
		begin
			sync_a    <= {pfd_clk, ref_clk, vco_clk, freq_down_pulse,
				freq_up_pulse};
			sync_b    <= sync_a;
			sync_prev <= sync_b;
		end
	end

	assign rise = sync_b & ~sync_prev;

	// Step trigger decode
	always_comb
	begin
		fine_tune_enable           = fine_tune_control[dsor_pkg::FT_ENABLE_BIT];
		step_trigger_source_select =
			fine_tune_control[dsor_pkg::FT_SERIAL_BIT];
		// A request bit going from zero to one is one software edge
		sw_up_event   = reg_wr && reg_addr == dsor_pkg::OFS_FINE_TUNE
			&& reg_wdata[dsor_pkg::FT_UP_BIT]
			&& !fine_tune_control[dsor_pkg::FT_UP_BIT]; // RQ6
		sw_down_event = reg_wr && reg_addr == dsor_pkg::OFS_FINE_TUNE
			&& reg_wdata[dsor_pkg::FT_DOWN_BIT]
			&& !fine_tune_control[dsor_pkg::FT_DOWN_BIT]; // RQ6
		up_req   = fine_tune_enable && (step_trigger_source_select
			? sw_up_event : rise[IU]); // RQ5
		down_req = fine_tune_enable && (step_trigger_source_select
			? sw_down_event : rise[ID]); // RQ8
		step_ext = NUM_W'(frequency_step_size); // RQ1
		next_ofs = num_ofs;
		// Both edges together cancel out
		if (up_req)
			next_ofs = next_ofs + step_ext; // RQ3
		if (down_req)
			next_ofs = next_ofs - step_ext; // RQ4
		next_num = numerator_base + num_ofs; // RQ2
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			num_ofs       <= '0;
			sdm_numerator <= '0;
		end
		else
		begin
			num_ofs       <= next_ofs;
			sdm_numerator <= next_num;
		end
	end

	// Prescalers on the sampled oscillator
	dsor_int_divider #(.W(3)) u_psa (
		.mclk      (mclk),
		.rst       (rst),
		.src_level (sync_b[IV]),
		.src_rise  (rise[IV]),
		.div_value (ps_divisor(prescale_control[dsor_pkg::PS_A_LSB +: 2])),
		.div_out   (prescaler_a)
	); // RQ9

	dsor_int_divider #(.W(3)) u_psb (
		.mclk      (mclk),
		.rst       (rst),
		.src_level (sync_b[IV]),
		.src_rise  (rise[IV]),
		.div_value (ps_divisor(prescale_control[dsor_pkg::PS_B_LSB +: 2])),
		.div_out   (prescaler_b)
	); // RQ9

	// Channel source muxes and dividers
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_ch
			assign sel_level[g] = src_pick(
				channel_source[g][dsor_pkg::CH_SRC_LSB +: 2],
				prescaler_a, prescaler_b, sync_b[IR]); // RQ12 RQ11
			dsor_int_divider #(.W(dsor_pkg::CH_DIV_W)) u_div (
				.mclk      (mclk),
				.rst       (rst),
				.src_level (sel_level[g]),
				.src_rise  (sel_level[g] & ~sel_prev[g]),
				.div_value (channel_source[g][dsor_pkg::CH_DIV_W-1:0]),
				.div_out   (div_out[g])
			); // RQ10
		end
	endgenerate

	// Only outputs one and four have CMOS buffers
	assign pol_p = {cmos_pol_four[dsor_pkg::POL4_P_BIT], 2'b00,
		cmos_pol_one[dsor_pkg::POL1_P_BIT]};
	assign pol_n = {cmos_pol_four[dsor_pkg::POL4_N_BIT], 2'b00,
		cmos_pol_one[dsor_pkg::POL1_N_BIT]};

	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			// Reference route skips the divider altogether
			if (bypass_routing_control[dsor_pkg::BYP_ROUTE_LSB + i])
				next_p[i] = sync_b[IR]; // RQ14 RQ13
			else
				next_p[i] = div_out[i];
			next_n[i] = ~next_p[i] ^ pol_n[i]; // RQ17
			next_p[i] = next_p[i] ^ pol_p[i]; // RQ17
		end
		if (!bypass_routing_control[dsor_pkg::BYP_ZERO_BIT])
			next_zero = 1'b0; // RQ15
		else if (bypass_routing_control[dsor_pkg::BYP_SRC_BIT])
			next_zero = sync_b[IP]; // RQ16
		else
			next_zero = sync_b[IR]; // RQ16
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			sel_prev          <= '0;
			out_p             <= '0;
			out_n             <= '0;
			clock_output_zero <= 1'b0;
		end
		else
		begin
			sel_prev          <= sel_level;
			out_p             <= next_p;
			out_n             <= next_n;
			clock_output_zero <= next_zero;
		end
	end

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence sw_up_write;
		reg_wr && reg_addr == dsor_pkg::OFS_FINE_TUNE
		&& fine_tune_control[dsor_pkg::FT_ENABLE_BIT]
		&& fine_tune_control[dsor_pkg::FT_SERIAL_BIT]
		&& !fine_tune_control[dsor_pkg::FT_UP_BIT]
		&& reg_wdata[dsor_pkg::FT_UP_BIT]
		&& !reg_wdata[dsor_pkg::FT_DOWN_BIT];
	endsequence

	step_up_add_a: assert property ( // RQ3
		(up_req && !down_req) |=> num_ofs == $past(num_ofs)
			+ NUM_W'($past(frequency_step_size)))
		else $error("up step did not add step size");

	step_down_sub_a: assert property ( // RQ4
		(down_req && !up_req) |=> num_ofs == $past(num_ofs)
			- NUM_W'($past(frequency_step_size)))
		else $error("down step did not subtract step size");

	disabled_hold_a: assert property ( // RQ8
		!fine_tune_control[dsor_pkg::FT_ENABLE_BIT] |=> $stable(num_ofs))
		else $error("numerator moved while fine tune disabled");

	serial_ignores_pin_a: assert property ( // RQ5
		(fine_tune_control[dsor_pkg::FT_SERIAL_BIT] && !reg_wr)
			|=> $stable(num_ofs))
		else $error("pin edge stepped in serial mode");

	sw_trigger_a: assert property ( // RQ6
		sw_up_write |=> num_ofs == $past(num_ofs)
			+ NUM_W'($past(frequency_step_size)))
		else $error("software up request did not step");

	numerator_sum_a: assert property ( // RQ2
		1'b1 |=> sdm_numerator == $past(numerator_base) + $past(num_ofs))
		else $error("numerator output wrong");

	zero_off_a: assert property ( // RQ15
		!bypass_routing_control[dsor_pkg::BYP_ZERO_BIT] |=>
			!clock_output_zero)
		else $error("output zero driven while disabled");

	zero_source_a: assert property ( // RQ16
		$stable(bypass_routing_control) && bypass_routing_control[
			dsor_pkg::BYP_ZERO_BIT] |=> clock_output_zero ==
			($past(bypass_routing_control[dsor_pkg::BYP_SRC_BIT])
			? $past(sync_b[IP]) : $past(sync_b[IR])))
		else $error("output zero source wrong");

	ref_route_a: assert property ( // RQ14
		bypass_routing_control[dsor_pkg::BYP_ROUTE_LSB + 1] |=>
			out_p[1] == $past(sync_b[IR]))
		else $error("reference route to output two wrong");

endmodule : dsor_top

// ---- verif/dsor_step_ctrl.sv ----
// Model of the external controller that drives the two step request pins.
// Assumes the bench raises cmd_up or cmd_dn for one cycle while busy is low.
`timescale 1ns/100ps
module dsor_step_ctrl (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// Step commands from the bench
	input  wire logic cmd_up,
	input  wire logic cmd_dn,
	// Step request pins and busy flag
	output logic      freq_up_pulse,
	output logic      freq_down_pulse,
	output logic      busy
);
	logic [3:0] cnt;

	assign busy = (cnt != 4'h0);

	// One rising edge per step, high four cycles and low at least five, above the
	// three cycles the pin sampler needs
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cnt             <= 4'h0;
			freq_up_pulse   <= 1'b0;
			freq_down_pulse <= 1'b0;
		end
		else if (cnt != 4'h0)
		begin
			cnt <= cnt - 4'h1;
			if (cnt == 4'h5)
			begin
				freq_up_pulse   <= 1'b0;
				freq_down_pulse <= 1'b0;
			end
		end
		else if (cmd_up || cmd_dn)
		begin
			cnt             <= 4'h8;
			freq_up_pulse   <= cmd_up;
			freq_down_pulse <= cmd_dn;
		end
	end
endmodule : dsor_step_ctrl

// ---- verif/tb.sv ----
// Self-checking bench for the step unit and the output clock routing.
// Assumes the step pins come from the controller model beside the design.
`timescale 1ns/100ps
module tb;
	typedef struct {
		logic [6:0]  addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
	} dsor_row_t;

	localparam int          WIN  = 4000;
	localparam logic [23:0] BASE = 24'hfffffe;

	logic        mclk;
	logic        rst;
	logic [6:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic [15:0] reg_rdata;
	logic        freq_up_pulse;
	logic        freq_down_pulse;
	logic [23:0] numerator_base;
	logic [23:0] sdm_numerator;
	logic        vco_clk;
	logic        ref_clk;
	logic        pfd_clk;
	logic        clock_output_zero;
	logic [3:0]  out_p;
	logic [3:0]  out_n;
	logic        cmd_up;
	logic        cmd_dn;
	logic        ctrl_busy;
	logic [15:0] d;
	int          error_cnt;
	int          total_checks;
	int          n;
	dsor_row_t   rows [11];

	dsor_top dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
		.freq_up_pulse(freq_up_pulse), .freq_down_pulse(freq_down_pulse),
		.numerator_base(numerator_base), .sdm_numerator(sdm_numerator),
		.vco_clk(vco_clk), .ref_clk(ref_clk), .pfd_clk(pfd_clk),
		.clock_output_zero(clock_output_zero), .out_p(out_p), .out_n(out_n));

	dsor_step_ctrl ctrl (.mclk(mclk), .rst(rst), .cmd_up(cmd_up),
		.cmd_dn(cmd_dn), .freq_up_pulse(freq_up_pulse),
		.freq_down_pulse(freq_down_pulse), .busy(ctrl_busy));

	// Sources kept slower than a quarter of mclk for the samplers
	initial begin mclk = 1'b0; forever #25 mclk = ~mclk; end
	initial begin vco_clk = 1'b0; forever #125 vco_clk = ~vco_clk; end
	initial begin ref_clk = 1'b0; forever #225 ref_clk = ~ref_clk; end
	initial begin pfd_clk = 1'b0; forever #325 pfd_clk = ~pfd_clk; end

	task final_report();
		if (error_cnt == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	task chk(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Edge counts jitter by one at each end of the window
	task chk_near(input int got, input int exp);
		total_checks++;
		if (got < exp - 2 || got > exp + 2)
		begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_near

	task wr(input logic [6:0] a, input logic [15:0] v);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask : wr

	task rd(input logic [6:0] a, output logic [15:0] v);
		@(posedge mclk);
		reg_addr <= a;
		repeat (2) @(posedge mclk);
		#1 v = reg_rdata;
	endtask : rd

	task settle();
		repeat (4) @(posedge mclk);
		#1;
	endtask : settle

	task pin(input logic up);
		int k;
		@(posedge mclk);
		cmd_up <= up;
		cmd_dn <= ~up;
		@(posedge mclk);
		cmd_up <= 1'b0;
		cmd_dn <= 1'b0;
		@(posedge mclk);
		for (k = 0; k < 20 && ctrl_busy === 1'b1; k++)
			@(posedge mclk);
		settle();
	endtask : pin

	task count(input int sel, output int cnt);
		logic prev;
		logic cur;
		cnt  = 0;
		prev = 1'b0;
		repeat (WIN)
		begin
			@(posedge mclk);
			#1 cur = (sel == 0) ? clock_output_zero : out_p[sel-1];
			if (cur === 1'b1 && prev === 1'b0)
				cnt++;
			prev = cur;
		end
	endtask : count

	initial
	begin
		#(50 * 60000);
		error_cnt++;
		final_report();
	end

	initial
	begin
		rst = 1'b1; reg_addr = 7'h00; reg_wdata = 16'h0000; reg_wr = 1'b0;
		cmd_up = 1'b0; cmd_dn = 1'b0; numerator_base = BASE;
		error_cnt = 0; total_checks = 0;
		rows = '{'{7'h19, 16'h7e00, 16'h7e00}, '{7'h2b, 16'hffff, 16'hffff},
			'{7'h38, 16'hffff, 16'hffff}, '{7'h3e, 16'h8001, 16'h8001},
			'{7'h43, 16'h4002, 16'h4002}, '{7'h48, 16'hc003, 16'hc003},
			'{7'h2f, 16'h0068, 16'h0068}, '{7'h3b, 16'h1800, 16'h1800},
			'{7'h4b, 16'h1800, 16'h1800}, '{7'h05, 16'h1234, 16'h0000},
			'{7'h03, 16'h0070, 16'h0070}};
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		settle();
		chk(sdm_numerator, BASE);
		foreach (rows[i])
		begin
			rd(rows[i].addr, d);
			chk({8'h00, d}, 24'h000000);
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, d);
			chk({8'h00, d}, {8'h00, rows[i].rdata});
		end
		settle();
		chk(sdm_numerator, BASE);
		// Serial triggers, numerator wraps modulo its width
		wr(7'h2b, 16'h0005);
		wr(7'h03, 16'h0018);
		wr(7'h03, 16'h0038);
		settle();
		chk(sdm_numerator, BASE + 24'h5);
		wr(7'h03, 16'h0018);
		wr(7'h03, 16'h0058);
		settle();
		chk(sdm_numerator, BASE);
		wr(7'h03, 16'h0018);
		wr(7'h03, 16'h0078);
		settle();
		chk(sdm_numerator, BASE);
		pin(1'b1);
		chk(sdm_numerator, BASE);
		wr(7'h03, 16'h0000);
		pin(1'b1);
		chk(sdm_numerator, BASE);
		wr(7'h03, 16'h0008);
		pin(1'b1);
		pin(1'b1);
		chk(sdm_numerator, BASE + 24'ha);
		pin(1'b0);
		chk(sdm_numerator, BASE + 24'h5);
		wr(7'h2b, 16'hffff);
		pin(1'b0);
		chk(sdm_numerator, BASE + 24'h5 - 24'h00ffff);
		// Reset in mid-run clears offset and registers
		@(posedge mclk);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		settle();
		chk(sdm_numerator, BASE);
		rd(7'h2b, d);
		chk({8'h00, d}, 24'h000000);
		// Clock routing, expected edges from source periods
		wr(7'h19, 16'h0400);
		count(0, n);
		chk_near(n, WIN * 50 / 450);
		wr(7'h19, 16'h0600);
		count(0, n);
		chk_near(n, WIN * 50 / 650);
		wr(7'h38, 16'h0002);
		count(1, n);
		chk_near(n, WIN * 50 / 2000);
		wr(7'h2f, 16'h0048);
		wr(7'h3e, 16'h4000);
		count(2, n);
		chk_near(n, WIN * 50 / 1500);
		// Prescaler a now at five, channel one still halves it
		count(1, n);
		chk_near(n, WIN * 50 / 2500);
		wr(7'h43, 16'h8005);
		count(3, n);
		chk_near(n, WIN * 50 / 2250);
		wr(7'h19, 16'h4000);
		count(4, n);
		chk_near(n, WIN * 50 / 450);
		wr(7'h38, 16'h8000);
		count(1, n);
		chk_near(n, WIN * 50 / 450);
		// Output one: positive CMOS pin inverts alone, then with the negative pin
		wr(7'h3b, 16'h0800);
		repeat (8)
		begin
			settle();
			chk({23'h0, out_p[0] ^ out_n[0]}, 24'h0);
		end
		wr(7'h3b, 16'h1800);
		repeat (8)
		begin
			settle();
			chk({23'h0, out_p[0] ^ out_n[0]}, 24'h1);
		end
		final_report();
	end
endmodule : tb
